// file: clock_tree_core.sv
// Display clock tree: transcoder symbol clocks, core display clock with
// fallback, and DSI 8X/4X levels; symbol, core, byte and escape clocks as tick enables.
// Assumes every tick input is a one-cycle pulse synchronous to clk.
`timescale 1ns/1ps

module clock_tree_core (
  input  wire logic                                 clk,
  input  wire logic                                 rst_n,
  clock_tree_if.device                              ctl,
  input  wire logic                                 ref_tick,
  input  wire logic                                 fallback_tick,
  input  wire logic                                 core_pll_tick,
  input  wire logic                                 power_save,
  input  wire logic [1:0]                           strap_in,
  input  wire logic [clock_tree_pkg::NUM_PORTS-1:0] port_tick,
  input  wire logic [clock_tree_pkg::NUM_DISPLAY_PLL-1:0]  display_pll_tick,
  input  wire logic [7:0]                           dsi_byte_in,
  output logic      [clock_tree_pkg::NUM_TRANS-1:0] trans_sym_tick,
  output logic                                      cd_tick,
  output logic                                      cd2x_tick,
  output logic                                      dsi_8x_lvl,
  output logic                                      dsi_4x_lvl,
  output logic                                      dsi_4x_q_lvl,
  output logic                                      dsi_byte_tick,
  output logic                                      dsi_esc_tick,
  output logic                                      dsi_fwd_tick,
  output logic      [7:0]                           dsi_fwd_byte
);

  // ************************************************************
  // Strap capture after reset release
  // ************************************************************
  logic       strap_done_r;
  logic [1:0] strap_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_done_r <= 1'b0;
      strap_r      <= clock_tree_pkg::STRAP_24;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      strap_r      <= strap_in;
    end
  end
  assign ctl.strap = strap_r;

  // ************************************************************
  // Core display PLL enable and lock
  // ************************************************************
  wire logic pll_run = ctl.pll_enable && !power_save;
  logic [4:0] lock_cnt_r;
  wire logic  locked = lock_cnt_r == clock_tree_pkg::LOCK_REF_TICKS;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) lock_cnt_r <= 5'h00;
    else if (!pll_run) lock_cnt_r <= 5'h00;
    else if (ref_tick && !locked) lock_cnt_r <= 5'(lock_cnt_r + 5'h01);
  end

  // ************************************************************
  // Double clock divider after the PLL
  // ************************************************************
  wire logic [1:0] div_eff = (ctl.double_div == 2'h0) ? 2'h1 : ctl.double_div;
  logic [1:0] div_cnt_r;
  wire logic  div_last = div_cnt_r == 2'(div_eff - 2'h1);
  wire logic  pll_div_tick = core_pll_tick && locked && div_last;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) div_cnt_r <= 2'h0;
    else if (!locked) div_cnt_r <= 2'h0;
    else if (core_pll_tick) div_cnt_r <= div_last ? 2'h0 : 2'(div_cnt_r + 2'h1);
  end

  // ************************************************************
  // Core clock source select with fallback
  // ************************************************************
  // Source flips only in a quiet cycle, at a whole 1X period while locked, so no
  // shortened pulse ever reaches the engine; costs a few cycles of latency.
  logic      on_pll_r;
  logic      cd_phase_r;
  // A lost lock stops the PLL ticks, so the odd phase is dropped there;
  // waiting for an even phase on a dead source would never leave it.
  wire logic quiet = !core_pll_tick && !fallback_tick && (!cd_phase_r || !locked);
  wire logic src2x = on_pll_r ? pll_div_tick : fallback_tick;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      on_pll_r   <= 1'b0;
      cd_phase_r <= 1'b0;
      cd2x_tick  <= 1'b0;
      cd_tick    <= 1'b0;
    end else begin
      if (on_pll_r != locked && quiet) begin
        on_pll_r   <= locked;
        cd_phase_r <= 1'b0;
      end else if (src2x) begin
        cd_phase_r <= !cd_phase_r;
      end
      cd2x_tick <= src2x;
      cd_tick   <= src2x && cd_phase_r;
    end
  end
  assign ctl.core_on_pll = on_pll_r;

  // ************************************************************
  // Core frequency readback
  // ************************************************************
  // PLL output halves the ratio product; 2X divider then divides by div_eff
  wire logic [15:0] ref_khz = (strap_r == clock_tree_pkg::STRAP_19P2) ? clock_tree_pkg::REF_19P2_KHZ :
                              (strap_r == clock_tree_pkg::STRAP_38P4) ? clock_tree_pkg::REF_38P4_KHZ :
                              clock_tree_pkg::REF_24_KHZ;
  wire logic [22:0] prod = 23'(ref_khz) * 23'(ctl.pll_ratio);
  wire logic [22:0] quot = 23'((prod >> 1) / 23'(div_eff));
  logic [23:0] freq_r;
  logic        locked_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      freq_r   <= clock_tree_pkg::FALLBACK_KHZ;
      locked_r <= 1'b0;
    end else begin
      freq_r   <= on_pll_r ? 24'(quot) : clock_tree_pkg::FALLBACK_KHZ;
      locked_r <= locked;
    end
  end
  assign ctl.core_freq_khz = freq_r;
  assign ctl.pll_locked    = locked_r;

  // ************************************************************
  // Transcoder symbol clocks
  // ************************************************************
  logic [clock_tree_pkg::NUM_TRANS-1:0] tact_r;
  genvar t;
  generate
    for (t = 0; t < clock_tree_pkg::NUM_TRANS; t++) begin : g_trans
      wire logic [2:0] sel  = ctl.trans_sel[t*clock_tree_pkg::TSEL_WIDTH +: 3];
      wire logic [1:0] pidx = 2'(sel - 3'h1);
      wire logic       ok   = sel != 3'h0 && sel <= 3'(clock_tree_pkg::NUM_PORTS)
                              && (pidx != clock_tree_pkg::PORT_A || t == clock_tree_pkg::TRANS_EDP);
      wire logic       ptk  = ok && port_tick[pidx];
      logic [2:0]      cnt_r;
      wire logic       last = cnt_r == clock_tree_pkg::SYMBOL_DIV_LAST;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          cnt_r             <= 3'h0;
          trans_sym_tick[t] <= 1'b0;
          tact_r[t]         <= 1'b0;
        end else begin
          tact_r[t]         <= ok;
          trans_sym_tick[t] <= ptk && last;
          if (!ok) cnt_r <= 3'h0;
          else if (ptk) cnt_r <= last ? 3'h0 : 3'(cnt_r + 3'h1);
        end
      end
    end
  endgenerate
  assign ctl.trans_active = tact_r;

  // ************************************************************
  // DSI clocks
  // ************************************************************
  // display_pll_tick marks each half period of the 8X clock, so a one-tick
  // offset of the 4X copy is a quarter of its period.
  wire logic dsi_edge = ctl.dsi_enable && display_pll_tick[ctl.dsi_pll_sel];
  wire logic [7:0] esc_eff = (ctl.esc_div == 8'h00) ? 8'h01 : ctl.esc_div;
  logic [3:0] half_r;
  logic [7:0] esc_r;
  wire logic  full8 = dsi_edge && half_r[0];
  wire logic  byte_now = dsi_edge && half_r == clock_tree_pkg::BYTE_HALF_LAST;
  wire logic  esc_last = esc_r == 8'(esc_eff - 8'h01);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      half_r        <= 4'h0;
      esc_r         <= 8'h00;
      dsi_8x_lvl    <= 1'b0;
      dsi_4x_lvl    <= 1'b0;
      dsi_4x_q_lvl  <= 1'b0;
      dsi_byte_tick <= 1'b0;
      dsi_esc_tick  <= 1'b0;
      dsi_fwd_tick  <= 1'b0;
      dsi_fwd_byte  <= 8'h00;
    end else if (!ctl.dsi_enable) begin
      half_r        <= 4'h0;
      esc_r         <= 8'h00;
      dsi_8x_lvl    <= 1'b0;
      dsi_4x_lvl    <= 1'b0;
      dsi_4x_q_lvl  <= 1'b0;
      dsi_byte_tick <= 1'b0;
      dsi_esc_tick  <= 1'b0;
      dsi_fwd_tick  <= 1'b0;
    end else begin
      if (dsi_edge) begin
        half_r     <= 4'(half_r + 4'h1);
        dsi_8x_lvl <= !dsi_8x_lvl;
      end
      if (dsi_edge && half_r[0])  dsi_4x_lvl   <= !dsi_4x_lvl;
      if (dsi_edge && !half_r[0]) dsi_4x_q_lvl <= !dsi_4x_q_lvl;
      dsi_byte_tick <= byte_now;
      if (full8) esc_r <= esc_last ? 8'h00 : 8'(esc_r + 8'h01);
      dsi_esc_tick <= full8 && esc_last;
      dsi_fwd_tick <= byte_now;
      if (byte_now) dsi_fwd_byte <= dsi_byte_in;
    end
  end

endmodule

// file: clock_tree_ctrl.sv
// Register end: software orders and status readback for the clock tree.
// Assumes a plain port master: one-cycle strobes, read data one cycle later.
`timescale 1ns/1ps
module clock_tree_ctrl (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic [7:0]         addr,
  input  wire logic [31:0]        wdata,
  input  wire logic               wr,
  input  wire logic               rd,
  output logic      [31:0]        rdata,
  clock_tree_if.controller        ctl
);

  // ************************************************************
  // Decode
  // ************************************************************
  wire logic hit_core  = addr == clock_tree_pkg::CORE_CTL_OFS;
  wire logic hit_trans = addr == clock_tree_pkg::TRANS_SEL_OFS;
  wire logic hit_dsi   = addr == clock_tree_pkg::DSI_CTL_OFS;
  wire logic hit_stat  = addr == clock_tree_pkg::STATUS_OFS;
  wire logic hit_freq  = addr == clock_tree_pkg::FREQ_OFS;

  logic [31:0] core_r;
  logic [31:0] trans_r;
  logic [31:0] dsi_r;
  logic [31:0] rdata_nxt;

  // Software owns ratio, divider and escape divisor choice for the strap
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_r  <= clock_tree_pkg::CORE_CTL_RST;
      trans_r <= clock_tree_pkg::TRANS_SEL_RST;
      dsi_r   <= clock_tree_pkg::DSI_CTL_RST;
      rdata   <= 32'h0000_0000;
    end else begin
      if (wr && hit_core)  core_r  <= wdata;
      if (wr && hit_trans) trans_r <= wdata;
      if (wr && hit_dsi)   dsi_r   <= wdata;
      rdata <= rdata_nxt;
    end
  end

  wire logic [31:0] status_word = {
    {(32 - clock_tree_pkg::ST_TACT_LSB - clock_tree_pkg::NUM_TRANS){1'b0}},
    ctl.trans_active, ctl.strap, ctl.core_on_pll, ctl.pll_locked};

  // Unmapped addresses read zero; a read with no strobe leaves zero too
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (rd) begin
      if (hit_core)  rdata_nxt = core_r;
      if (hit_trans) rdata_nxt = trans_r;
      if (hit_dsi)   rdata_nxt = dsi_r;
      if (hit_stat)  rdata_nxt = status_word;
      if (hit_freq)  rdata_nxt = {8'h00, ctl.core_freq_khz};
    end
  end

  // ************************************************************
  // Orders to the clock tree
  // ************************************************************
  assign ctl.pll_enable  = core_r[clock_tree_pkg::CORE_EN_BIT];
  assign ctl.double_div  = core_r[clock_tree_pkg::CORE_DIV_LSB +: 2];
  assign ctl.pll_ratio   = core_r[clock_tree_pkg::CORE_RAT_LSB +: 7];
  assign ctl.trans_sel   = trans_r[clock_tree_pkg::NUM_TRANS*clock_tree_pkg::TSEL_WIDTH-1:0];
  assign ctl.dsi_enable  = dsi_r[clock_tree_pkg::DSI_EN_BIT];
  assign ctl.dsi_pll_sel = dsi_r[clock_tree_pkg::DSI_PLL_BIT];
  assign ctl.esc_div     = dsi_r[clock_tree_pkg::DSI_ESC_LSB +: 8];

endmodule

// file: clock_tree_if.sv
// Control and status link between the register end and the clock tree.
// Assumes both ends share clk; the testbench instantiates and joins them.
`timescale 1ns/1ps
interface clock_tree_if;
  logic                                               pll_enable;
  logic [1:0]                                         double_div;
  logic [6:0]                                         pll_ratio;
  logic [clock_tree_pkg::NUM_TRANS*clock_tree_pkg::TSEL_WIDTH-1:0] trans_sel;
  logic                                               dsi_enable;
  logic                                               dsi_pll_sel;
  logic [7:0]                                         esc_div;
  logic                                               pll_locked;
  logic                                               core_on_pll;
  logic [1:0]                                         strap;
  logic [clock_tree_pkg::NUM_TRANS-1:0]               trans_active;
  logic [23:0]                                        core_freq_khz;

  modport device (
    input  pll_enable, double_div, pll_ratio, trans_sel, dsi_enable, dsi_pll_sel, esc_div,
    output pll_locked, core_on_pll, strap, trans_active, core_freq_khz
  );
  modport controller (
    output pll_enable, double_div, pll_ratio, trans_sel, dsi_enable, dsi_pll_sel, esc_div,
    input  pll_locked, core_on_pll, strap, trans_active, core_freq_khz
  );
endinterface

// file: clock_tree_monitor.sv
// Assertions on the link between the register end and the clock tree.
// Assumes clk and rst_n of both ends; all other inputs are link signals.
`timescale 1ns/1ps
module clock_tree_monitor (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        pll_enable,
  input wire logic [1:0]  double_div,
  input wire logic [6:0]  pll_ratio,
  input wire logic [11:0] trans_sel,
  input wire logic        dsi_enable,
  input wire logic        pll_locked,
  input wire logic        core_on_pll,
  input wire logic [1:0]  strap,
  input wire logic [3:0]  trans_active,
  input wire logic [23:0] core_freq_khz
);
  logic [15:0] ref_khz;
  logic [31:0] div_eff;
  logic [23:0] exp_khz;
  logic [3:0]  sel_ok;

  assign ref_khz = (strap == clock_tree_pkg::STRAP_19P2) ? clock_tree_pkg::REF_19P2_KHZ :
                   (strap == clock_tree_pkg::STRAP_38P4) ? clock_tree_pkg::REF_38P4_KHZ :
                   clock_tree_pkg::REF_24_KHZ;
  assign div_eff = (double_div == 2'h0) ? 32'h0000_0001 : 32'(double_div);
  assign exp_khz = 24'(32'(ref_khz) * 32'(pll_ratio) / (div_eff * 32'h0000_0002));

  // Port A is legal for the embedded transcoder only
  for (genvar t = 0; t < 4; t++) begin : g_sel
    assign sel_ok[t] = (trans_sel[3*t+:3] >= 3'h1) && (trans_sel[3*t+:3] <= 3'h4) &&
                       ((trans_sel[3*t+:3] != 3'h1) || (t == clock_tree_pkg::TRANS_EDP));
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_reset_state: assert property ($rose(rst_n) |-> !pll_enable && !core_on_pll &&
    trans_sel == 12'h000 && !dsi_enable && double_div == 2'h1)
    else $error("link not in reset state after release");
  a_fallback_freq: assert property (!$past(core_on_pll) |->
    core_freq_khz == clock_tree_pkg::FALLBACK_KHZ) else $error("fallback frequency wrong");
  a_pll_freq_value: assert property ($past(core_on_pll) && $stable(pll_ratio) &&
    $stable(double_div) && $stable(strap) |-> core_freq_khz == exp_khz)
    else $error("core frequency does not match ratio");
  a_trans_sel_map: assert property (trans_active == $past(sel_ok))
    else $error("transcoder activity does not match select");
  a_unlock_drop: assert property ($fell(pll_enable) |-> ##[1:2] !pll_locked)
    else $error("lock kept after disable");
  a_lock_wait: assert property ($rose(pll_enable) && !pll_locked |-> !pll_locked[*8])
    else $error("lock reported too early");
  a_onpll_locked: assert property ($rose(core_on_pll) |-> pll_locked)
    else $error("switched to pll without lock");
  a_onpll_leave: assert property (!pll_locked |-> ##[0:64] !core_on_pll)
    else $error("core clock stayed on unlocked pll");
endmodule

// file: clock_tree_pkg.sv
// Shared constants for the display clock tree: sizes, register map,
// field positions, reset values and divider counts.
// Assumes both ends and the testbench refer to names as clock_tree_pkg::name.
package clock_tree_pkg;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int NUM_TRANS = 4;
  localparam int NUM_PORTS = 4;
  localparam int NUM_DISPLAY_PLL  = 2;
  localparam logic [1:0] PORT_A    = 2'h0;
  localparam int         TRANS_EDP = 0;

  // ************************************************************
  // Divider and timing counts (in ticks)
  // ************************************************************
  localparam logic [2:0] SYMBOL_DIV_LAST = 3'h4;   // Divide by 5
  localparam logic [3:0] BYTE_HALF_LAST  = 4'hF;   // 16 half periods of 8X
  localparam logic [4:0] LOCK_REF_TICKS  = 5'h10;  // Reference ticks to lock

  // ************************************************************
  // Reference strap codes and frequencies in kHz
  // ************************************************************
  localparam logic [1:0]  STRAP_24       = 2'h0;
  localparam logic [1:0]  STRAP_19P2     = 2'h1;
  localparam logic [1:0]  STRAP_38P4     = 2'h2;
  localparam logic [15:0] REF_24_KHZ     = 16'h5DC0;
  localparam logic [15:0] REF_19P2_KHZ   = 16'h4B00;
  localparam logic [15:0] REF_38P4_KHZ   = 16'h9600;
  localparam logic [23:0] FALLBACK_KHZ   = 24'h00_C350;

  // ************************************************************
  // Register offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] CORE_CTL_OFS  = 8'h00;
  localparam logic [7:0] TRANS_SEL_OFS = 8'h04;
  localparam logic [7:0] DSI_CTL_OFS   = 8'h08;
  localparam logic [7:0] STATUS_OFS    = 8'h0C;
  localparam logic [7:0] FREQ_OFS      = 8'h10;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CORE_EN_BIT   = 0;
  localparam int CORE_DIV_LSB  = 1;   // 2 bits
  localparam int CORE_RAT_LSB  = 8;   // 7 bits
  localparam int TSEL_WIDTH    = 3;   // Per transcoder, 0 = off
  localparam int DSI_EN_BIT    = 0;
  localparam int DSI_PLL_BIT   = 1;
  localparam int DSI_ESC_LSB   = 8;   // 8 bits
  localparam int ST_LOCK_BIT   = 0;
  localparam int ST_ONPLL_BIT  = 1;
  localparam int ST_STRAP_LSB  = 2;   // 2 bits
  localparam int ST_TACT_LSB   = 4;   // NUM_TRANS bits

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [31:0] CORE_CTL_RST  = 32'h0000_0002;  // PLL off, divider 1
  localparam logic [31:0] TRANS_SEL_RST = 32'h0000_0000;  // All off
  localparam logic [31:0] DSI_CTL_RST   = 32'h0000_0100;  // Off, divisor 1

endpackage

// file: tb_top.sv
// Bench joining the register end and the clock tree through their link.
// Assumes package, link, both ends and monitor are compiled before it.
`timescale 1ns/1ps
module tb_top;
  logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
  logic [7:0]  addr = 8'h00, dsi_byte_in = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, last_rd, wm, we;
  logic        ref_tick = 1'b0, fallback_tick = 1'b0, core_pll_tick = 1'b0;
  logic        power_save = 1'b0, clr = 1'b0, port_on = 1'b0, dsi_on = 1'b0;
  logic [1:0]  strap_in = 2'h0, display_pll_tick = 2'h0, dt;
  logic [3:0]  port_tick = 4'h0, pt, trans_sym_tick;
  logic        dsi_8x_lvl, dsi_4x_lvl, dsi_4x_q_lvl, dsi_byte_tick, dsi_esc_tick, dsi_fwd_tick;
  logic        cd_tick, cd2x_tick, fb_d;
  logic [7:0]  dsi_fwd_byte, byte_d;
  logic [31:0] exp_q[$], msk_q[$];
  int          seed = 74, n_mismatch = 0, n_checks = 0;
  int          in_port[4], out_sym[4], n_edge, n_byte, n_esc, n_fwd, n_cd2x, n_cd;
  logic [6:0]  rat[3][5] = '{'{7'h0F, 7'h10, 7'h1A, 7'h2E, 7'h36},
                             '{7'h12, 7'h14, 7'h20, 7'h3A, 7'h44},
                             '{7'h09, 7'h0A, 7'h10, 7'h1D, 7'h22}};
  logic [31:0] frq[2][5] = '{'{32'h0002_BF20, 32'h0002_EE00, 32'h0004_C2C0, 32'h0008_6C40,
                               32'h0009_E340}, '{32'h0002_A300, 32'h0002_EE00, 32'h0004_B000,
                               32'h0008_7F00, 32'h0009_F600}};

  clock_tree_if i_clock_tree_if ();
  clock_tree_ctrl i_clock_tree_ctrl (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .ctl(i_clock_tree_if.controller));
  clock_tree_core i_clock_tree_core (.clk(clk), .rst_n(rst_n), .ctl(i_clock_tree_if.device),
    .ref_tick(ref_tick), .fallback_tick(fallback_tick), .core_pll_tick(core_pll_tick),
    .power_save(power_save), .strap_in(strap_in), .port_tick(port_tick),
    .display_pll_tick(display_pll_tick), .dsi_byte_in(dsi_byte_in), .trans_sym_tick(trans_sym_tick),
    .cd_tick(cd_tick), .cd2x_tick(cd2x_tick), .dsi_8x_lvl(dsi_8x_lvl),
    .dsi_4x_lvl(dsi_4x_lvl), .dsi_4x_q_lvl(dsi_4x_q_lvl), .dsi_byte_tick(dsi_byte_tick),
    .dsi_esc_tick(dsi_esc_tick), .dsi_fwd_tick(dsi_fwd_tick), .dsi_fwd_byte(dsi_fwd_byte));
  clock_tree_monitor i_clock_tree_monitor (.clk(clk), .rst_n(rst_n),
    .pll_enable(i_clock_tree_if.pll_enable), .double_div(i_clock_tree_if.double_div),
    .pll_ratio(i_clock_tree_if.pll_ratio), .trans_sel(i_clock_tree_if.trans_sel),
    .dsi_enable(i_clock_tree_if.dsi_enable), .pll_locked(i_clock_tree_if.pll_locked),
    .core_on_pll(i_clock_tree_if.core_on_pll), .strap(i_clock_tree_if.strap),
    .trans_active(i_clock_tree_if.trans_active),
    .core_freq_khz(i_clock_tree_if.core_freq_khz));

  always #50 clk = ~clk;

  // ************************************************************
  // Random ticks and counters
  // ************************************************************
  // Sparse core ticks leave quiet cycles for the source switch
  always @(posedge clk) begin
    pt = port_on ? 4'($random(seed)) : 4'h0;
    dt = dsi_on ? 2'($random(seed)) : 2'h0;
    ref_tick <= 1'($random(seed));
    fallback_tick <= (2'($random(seed)) == 2'h0);
    core_pll_tick <= (2'($random(seed)) == 2'h0);
    dsi_byte_in <= 8'($random(seed));
    port_tick <= pt;
    display_pll_tick <= dt;
    for (int k = 0; k < 4; k++) begin
      in_port[k] <= clr ? 0 : in_port[k] + int'(pt[k]);
      out_sym[k] <= clr ? 0 : out_sym[k] + int'(trans_sym_tick[k]);
    end
    n_edge <= clr ? 0 : n_edge + int'(dt[1]);
    n_byte <= clr ? 0 : n_byte + int'(dsi_byte_tick);
    n_esc <= clr ? 0 : n_esc + int'(dsi_esc_tick);
    n_fwd <= clr ? 0 : n_fwd + int'(dsi_fwd_tick);
    n_cd2x <= clr ? 0 : n_cd2x + int'(cd2x_tick);
    n_cd <= clr ? 0 : n_cd + int'(cd_tick);
    // On fallback each 2X tick follows its input tick by one cycle
    if (port_on) chk(32'(cd2x_tick), 32'(fb_d));
    if (dsi_fwd_tick) chk(32'(dsi_fwd_byte), 32'(byte_d));
    fb_d <= fallback_tick;
    byte_d <= dsi_byte_in;
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_d) begin
      wm = msk_q.pop_front();
      we = exp_q.pop_front();
      if (wm != 32'h0000_0000) chk(rdata & wm, we & wm);
    end
    rd_d <= rd;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge clk);
    rd <= 1'b0;
    #1 last_rd = rdata;
  endtask

  task automatic poll(input int b, input logic v);
    last_rd = {32{~v}};
    for (int i = 0; i < 100 && last_rd[b] !== v; i++) begin
      rd_reg(clock_tree_pkg::STATUS_OFS, 32'h0000_0000, 32'h0000_0000);
    end
    chk(32'(last_rd[b]), 32'(v));
  endtask

  task automatic do_reset(input logic [1:0] s);
    @(posedge clk);
    strap_in <= s;
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask

  task automatic run_span(input int n, input bit dsi);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    port_on <= !dsi;
    dsi_on <= dsi;
    repeat (n) @(posedge clk);
    port_on <= 1'b0;
    dsi_on <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    for (int s = 0; s < 3; s++) begin
      do_reset(2'(s));
      if (s == 0) begin
        wr_reg(clock_tree_pkg::STATUS_OFS, 32'hFFFF_FFFF);
        rd_reg(clock_tree_pkg::CORE_CTL_OFS, clock_tree_pkg::CORE_CTL_RST, '1);
        rd_reg(clock_tree_pkg::TRANS_SEL_OFS, clock_tree_pkg::TRANS_SEL_RST, '1);
        rd_reg(clock_tree_pkg::DSI_CTL_OFS, clock_tree_pkg::DSI_CTL_RST, '1);
        rd_reg(clock_tree_pkg::STATUS_OFS, 32'h0000_0000, 32'h0000_00FF);
        rd_reg(clock_tree_pkg::FREQ_OFS, 32'(clock_tree_pkg::FALLBACK_KHZ), '1);
        rd_reg(8'h14, 32'h0000_0000, '1);
      end
      for (int k = 0; k < 5; k++) begin
        wr_reg(clock_tree_pkg::CORE_CTL_OFS, {17'h0_0000, rat[s][k], 5'h00, 3'h3});
        poll(clock_tree_pkg::ST_ONPLL_BIT, 1'b1);
        rd_reg(clock_tree_pkg::STATUS_OFS, {28'h000_0000, 2'(s), 2'h3}, 32'h0000_000F);
        rd_reg(clock_tree_pkg::FREQ_OFS, frq[s != 0][k], 32'h00FF_FFFF);
        if (k == 0) begin
          @(posedge clk);
          power_save <= 1'b1;
          poll(clock_tree_pkg::ST_LOCK_BIT, 1'b0);
          @(posedge clk);
          power_save <= 1'b0;
          poll(clock_tree_pkg::ST_ONPLL_BIT, 1'b1);
        end
        wr_reg(clock_tree_pkg::CORE_CTL_OFS, clock_tree_pkg::CORE_CTL_RST);
        poll(clock_tree_pkg::ST_ONPLL_BIT, 1'b0);
        rd_reg(clock_tree_pkg::FREQ_OFS, 32'(clock_tree_pkg::FALLBACK_KHZ), '1);
      end
    end
    // Transcoder 1 asks for port A and must stay silent
    wr_reg(clock_tree_pkg::TRANS_SEL_OFS, {20'h0_0000, 12'h0C9});
    run_span(200, 1'b0);
    chk(out_sym[0], in_port[0] / 5);
    chk(out_sym[1], 0);
    chk(out_sym[2], in_port[2] / 5);
    chk(out_sym[3], 0);
    chk(32'(n_cd2x - 2 * n_cd > 1 || 2 * n_cd > n_cd2x || n_cd2x == 0), 32'h0000_0000);
    rd_reg(clock_tree_pkg::STATUS_OFS, 32'h0000_0050, 32'h0000_00F0);
    wr_reg(clock_tree_pkg::DSI_CTL_OFS, 32'h0000_0303);
    run_span(300, 1'b1);
    chk(n_byte, n_edge / 16);
    chk(n_fwd, n_edge / 16);
    chk(n_esc, n_edge / 6);
    chk(32'({dsi_4x_q_lvl, dsi_4x_lvl, dsi_8x_lvl}),
        32'({1'((n_edge + 1) / 2), 1'(n_edge / 2), 1'(n_edge)}));
    wr_reg(clock_tree_pkg::DSI_CTL_OFS, 32'h0000_0302);
    repeat (3) @(posedge clk);
    chk(32'({dsi_4x_q_lvl, dsi_4x_lvl, dsi_8x_lvl}), 32'h0000_0000);
    print_verdict();
  end

  initial begin
    #2_000_000;
    n_mismatch++;
    print_verdict();
  end
endmodule
